// File: shared/rtcia_map.vh
// Purpose: Register offsets, fields, reset values and timing counts for the indirect access port.
// Assumes: Special-function register bus with 8-bit data and 8-bit address.
// Notes: Definitions only.
`ifndef RTCIA_MAP_VH
`define RTCIA_MAP_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define RTCIA_SELECT_OFFSET 8'hAC
`define RTCIA_DATA_OFFSET 8'hAD

// ----------------------------------------
// Select register fields
// ----------------------------------------
`define RTCIA_BUSY_BIT 7
`define RTCIA_AUTO_BIT 6
`define RTCIA_UNUSED_BIT 5
`define RTCIA_FAST_BIT 4
`define RTCIA_INDEX_MSB 3
`define RTCIA_INDEX_LSB 0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RTCIA_SELECT_RESET 8'h00
`define RTCIA_DATA_RESET 8'h00

// ----------------------------------------
// Internal index map
// ----------------------------------------
`define RTCIA_SNAP_FIRST 4'h0
`define RTCIA_SNAP_LAST 4'h3
`define RTCIA_WAKE_FIRST 4'h8
`define RTCIA_WAKE_LAST 4'hB

// ----------------------------------------
// Transfer length in system clock cycles
// ----------------------------------------
`define RTCIA_CYCLES_NORMAL 4'h7
`define RTCIA_CYCLES_FAST 4'h6

`endif

// File: src/rtcia_core_regs.v
// Purpose: Internal register file of the clock core as seen by the access port.
// Assumes: Sixteen byte entries; read data registered.
// Notes: Stands in for the core's storage so the port has a real far end.
`default_nettype none

module rtcia_core_regs #(
   parameter DEPTH_LOG2 = 4,
   parameter WIDTH = 8
) (
   input wire clk_in,
   input wire rst_in,
   input wire wr_en_in,
   input wire [DEPTH_LOG2-1:0] index_in,
   input wire [WIDTH-1:0] wr_data_in,
   output reg [WIDTH-1:0] rd_data_out
);

   reg [WIDTH-1:0] mem_reg [0:(1<<DEPTH_LOG2)-1];

   // ----------------------------------------
   // Storage; no reset, like retained core state
   // ----------------------------------------
   always @(posedge clk_in) begin
      if (wr_en_in) begin
         mem_reg[index_in] <= wr_data_in;
      end
   end

   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         rd_data_out <= {WIDTH{1'b0}};
      end else begin
         rd_data_out <= mem_reg[index_in];
      end
   end

endmodule

`default_nettype wire

// File: src/rtcia_port.v
// Purpose: Indirect access port from the special-function bus to the clock core registers.
// Assumes: Bus strobes are one-cycle pulses synchronous to clk_in; one access per cycle.
// Notes: Bus writes during a transfer are dropped; software should poll busy first.
//
// Overview of operation
// - Busy bit reports state; writing one reads
// - Bit six enables automatic follow-on reads
// - Bit five reads zero, writes ignored
// - Bit four selects shortened strobe timing
// - Low four bits select internal register
// - Index increments after snapshot/wake accesses
// - Data register holds last moved byte
// - Data write starts indirect write
// - Transfer takes seven cycles, six fast
// - Auto-fetch: data read starts next read
// - Snapshot 0x0-0x3, wake match 0x8-0xB
`default_nettype none
`include "rtcia_map.vh"

module rtcia_port (
   input wire clk_in,
   input wire rst_in,
   input wire [7:0] sfr_addr_in,
   input wire sfr_wr_in,
   input wire sfr_rd_in,
   input wire [7:0] sfr_wdata_in,
   output reg [7:0] sfr_rdata_out,
   output reg busy_out
);

   localparam ST_IDLE = 2'b00;
   localparam ST_READ = 2'b01;
   localparam ST_WRITE = 2'b10;

   reg [1:0] state_reg;
   reg [1:0] state_next;
   reg [3:0] count_reg;
   reg [3:0] count_next;
   reg auto_reg;
   reg auto_next;
   reg fast_reg;
   reg fast_next;
   reg [3:0] index_reg;
   reg [3:0] index_next;
   reg [7:0] data_reg;
   reg [7:0] data_next;
   reg [7:0] rdata_next;
   reg core_wr;
   reg [3:0] core_index;
   reg [3:0] xfer_len;
   reg multi_byte;
   wire [7:0] core_rdata;
   wire sel_hit;
   wire dat_hit;

   assign sel_hit = (sfr_addr_in == `RTCIA_SELECT_OFFSET);
   assign dat_hit = (sfr_addr_in == `RTCIA_DATA_OFFSET);

   rtcia_core_regs #(
      .DEPTH_LOG2(4),
      .WIDTH(8)
   ) u_core (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .wr_en_in(core_wr),
      .index_in(core_index),
      .wr_data_in(data_reg),
      .rd_data_out(core_rdata)
   );

   // ----------------------------------------
   // Next-state logic
   // ----------------------------------------
   always @* begin
      state_next = state_reg;
      count_next = count_reg;
      auto_next = auto_reg;
      fast_next = fast_reg;
      index_next = index_reg;
      data_next = data_reg;
      core_wr = 1'b0;
      core_index = index_reg;
      xfer_len = fast_reg ? `RTCIA_CYCLES_FAST : `RTCIA_CYCLES_NORMAL;
      // multi-byte ranges
      // Snapshot range starts at index zero, so only its top bound is tested
      multi_byte = (index_reg <= `RTCIA_SNAP_LAST) ||
         ((index_reg >= `RTCIA_WAKE_FIRST) && (index_reg <= `RTCIA_WAKE_LAST));
      case (state_reg)
         ST_IDLE: begin
            if (sfr_wr_in && sel_hit) begin
               auto_next = sfr_wdata_in[`RTCIA_AUTO_BIT];
               fast_next = sfr_wdata_in[`RTCIA_FAST_BIT];
               index_next = sfr_wdata_in[`RTCIA_INDEX_MSB:`RTCIA_INDEX_LSB];
               if (sfr_wdata_in[`RTCIA_BUSY_BIT]) begin
                  state_next = ST_READ;
                  count_next = 4'h1;
               end
            end else if (sfr_wr_in && dat_hit) begin
               data_next = sfr_wdata_in;
               state_next = ST_WRITE;
               count_next = 4'h1;
            end else if (sfr_rd_in && dat_hit && auto_reg) begin
               state_next = ST_READ;
               count_next = 4'h1;
            end
         end
         ST_READ, ST_WRITE: begin
            // Mid-transfer bus writes are dropped to keep the transfer consistent
            if (count_reg == xfer_len) begin
               if (state_reg == ST_READ) begin
                  data_next = core_rdata;
               end else begin
                  core_wr = 1'b1;
               end
               if (multi_byte) begin
                  index_next = index_reg + 4'h1;
               end
               state_next = ST_IDLE;
               count_next = 4'h0;
            end else begin
               count_next = count_reg + 4'h1;
            end
         end
         default: begin
            state_next = ST_IDLE;
            count_next = 4'h0;
         end
      endcase
   end

   // ----------------------------------------
   // Read data mux
   // ----------------------------------------
   always @* begin
      rdata_next = 8'h00;
      if (sel_hit) begin
         rdata_next = {(state_next != ST_IDLE), auto_next, 1'b0, fast_next, index_next};
      end else if (dat_hit) begin
         rdata_next = data_next;
      end
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         state_reg <= ST_IDLE;
         count_reg <= 4'h0;
         auto_reg <= 1'b0;
         fast_reg <= 1'b0;
         index_reg <= 4'h0;
         data_reg <= `RTCIA_DATA_RESET;
         sfr_rdata_out <= 8'h00;
         busy_out <= 1'b0;
      end else begin
         state_reg <= state_next;
         count_reg <= count_next;
         auto_reg <= auto_next;
         fast_reg <= fast_next;
         index_reg <= index_next;
         data_reg <= data_next;
         sfr_rdata_out <= rdata_next;
         busy_out <= (state_next != ST_IDLE);
      end
   end

endmodule

`default_nettype wire

// File: sim/rtcia_core_model.sv
// Purpose: Reference store for the core registers.
// Assumes: Sixteen byte slots, never reset.
// Notes: Read and written by the bench model only.
`default_nettype none
module rtcia_core_model;
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] mem [16];
endmodule
`default_nettype wire

// File: sim/rtcia_port_props.sv
// Purpose: Timing and view checks on the port.
// Assumes: Bound to every rtcia_port.
// Notes: cfg_reg shadows accepted select writes.
`default_nettype none
module rtcia_port_props (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [7:0] sfr_addr_in,
   input wire logic sfr_wr_in,
   input wire logic sfr_rd_in,
   input wire logic [7:0] sfr_wdata_in,
   input wire logic [7:0] sfr_rdata_out,
   input wire logic busy_out
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);
   logic [7:0] cfg_reg;
   wire logic go = !busy_out;
   wire logic sa = sfr_addr_in == 8'hAC;
   wire logic sd = sfr_addr_in == 8'hAD;
   always @(posedge clk_in or posedge rst_in)
      if (rst_in) cfg_reg <= 8'h00;
      else if (go && sfr_wr_in && sa) cfg_reg <= sfr_wdata_in;
   property p_start; go && sfr_wr_in && sa && sfr_wdata_in[7] |=> busy_out; endproperty
   a_start: assert property (p_start) else $error("no read start");
   property p_hold; go && sfr_wr_in && sa && !sfr_wdata_in[7] |=> !busy_out; endproperty
   a_hold: assert property (p_hold) else $error("stray start");
   property p_len; $rose(busy_out) |-> busy_out[*6] ##1 (busy_out == !cfg_reg[4]); endproperty
   a_len: assert property (p_len) else $error("bad length");
   property p_view; sa |=> sfr_rdata_out[7:4] == {busy_out, cfg_reg[6], 1'b0, cfg_reg[4]}; endproperty
   a_view: assert property (p_view) else $error("bad select view");
   property p_wr; go && sfr_wr_in && sd |=> busy_out; endproperty
   a_wr: assert property (p_wr) else $error("no write start");
   property p_auto; go && sfr_rd_in && !sfr_wr_in && sd |=> busy_out == cfg_reg[6]; endproperty
   a_auto: assert property (p_auto) else $error("bad auto fetch");
   property p_idle; go && !sfr_wr_in && !sfr_rd_in |=> !busy_out; endproperty
   a_idle: assert property (p_idle) else $error("busy unasked");
   property p_map; !sa && !sd |=> sfr_rdata_out == 8'h00; endproperty
   a_map: assert property (p_map) else $error("unmapped not zero");
endmodule
bind rtcia_port rtcia_port_props i_props (.clk_in, .rst_in, .sfr_addr_in, .sfr_wr_in,
   .sfr_rd_in, .sfr_wdata_in, .sfr_rdata_out, .busy_out);
`default_nettype wire

// File: sim/testbench.sv
// Purpose: Self-checking bench for the access port.
// Assumes: Strobes driven at falling edges.
// Notes: Model keeps select, data and core copy.
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_in = 0, rst_in = 1, wr = 0, rd = 0;
   logic [7:0] addr = 0, wd = 0, sel, dat, q, a;
   wire logic [7:0] rdata;
   wire logic busy;
   int fails = 0, comparisons = 0, cycles = 0;
   rtcia_core_model i_core();
   rtcia_port i_dut (.clk_in, .rst_in, .sfr_addr_in(addr), .sfr_wr_in(wr), .sfr_rd_in(rd),
      .sfr_wdata_in(wd), .sfr_rdata_out(rdata), .busy_out(busy));
   initial forever #10 clk_in = ~clk_in;
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 5000) begin
         fails++;
         report_and_stop();
      end
   end
   task report_and_stop;
      if (fails == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task chk(input [7:0] got, input [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Idle cycle between accesses keeps strobes one cycle wide
   // no read-modify-write on data
   task acc(input [7:0] ad, input w, input r, input [7:0] d);
      @(negedge clk_in);
      addr = ad; wr = w; rd = r; wd = d;
      @(negedge clk_in);
      wr = 0; rd = 0; q = rdata;
   endtask
   task look;
      acc(8'hAC, 0, 0, 8'h00);
      chk(q, sel);
      acc(8'hAD, 0, 0, 8'h00);
      chk(q, dat);
   endtask
   task fin(input w, input [7:0] skip);
      int n;
      n = 0;
      while (busy === 1'b1 && n < 20) begin
         n++;
         @(negedge clk_in);
      end
      chk(8'(n), (sel[4] ? 8'h06 : 8'h07) - skip);
      if (w) i_core.mem[sel[3:0]] = dat;
      else dat = i_core.mem[sel[3:0]];
      if (!sel[2]) sel[3:0] = sel[3:0] + 4'h1;
      sel[7] = 1'b0;
      look();
   endtask
   initial begin
      void'($urandom(32'h754F));
      repeat (16) @(negedge clk_in);
      rst_in = 0;
      sel = 8'h00;
      dat = 8'h00;
      look();
      a = 8'($urandom);
      if (a[7:1] == 7'h56) a = 8'h00;
      acc(a, 1, 0, 8'hFF);
      acc(a, 0, 1, 8'h00);
      chk(q, 8'h00);
      look();
      for (int k = 0; k < 4; k++) begin
         a = 8'($urandom);
         sel = {3'b000, k[1], k[0], 3'h0};
         acc(8'hAC, 1, 0, sel | {2'b00, a[5], 5'h00});
         look();
         repeat (4) begin
            dat = 8'($urandom);
            acc(8'hAD, 1, 0, dat);
            fin(1, 0);
         end
         sel[7:6] = 2'b11;
         sel[3:0] = {k[0], 3'h0};
         acc(8'hAC, 1, 0, sel);
         acc(8'hAC, 1, 0, 8'h25);
         fin(0, 2);
         repeat (3) begin
            acc(8'hAD, 0, 1, 8'h00);
            chk(q, dat);
            fin(0, 0);
         end
      end
      sel = 8'h05;
      dat = 8'($urandom);
      acc(8'hAC, 1, 0, sel);
      acc(8'hAD, 1, 0, dat);
      fin(1, 0);
      acc(8'hAD, 0, 1, 8'h00);
      chk(q, dat);
      chk({7'h00, busy}, 8'h00);
      report_and_stop();
   end
endmodule
`default_nettype wire
